// ### pca_compare_pwm_wdt_unit.sv
// compare, pwm and watchdog side of a five module timer array with apb registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// - compare plus equal enable gives software timer
// - 16-bit equality sets event flag, irq if enabled
// - event flags stay set until software clears
// - low byte write clears, high write sets compare_enable
// - pin flip mode inverts pin and flags on match
// - watchdog on module 4 with reset enable
// - each watchdog match issues device reset
// - clearing reset enable blocks watchdog reset
// - pwm output low while count below compare
// - pwm goes high on equality until wrap
// - at wrap output low unless high byte is zero, high byte reloads low
// - pwm period is 256 count pulses
// - duty zero fully high, 255 one count
// - enhanced enable bit, clear after reset
// - external counting mode overrides enhanced mode
// - enhanced gives each module own counter, zero shared
// - per counter run bits replace shared run bit
// - per counter idle stops replace shared idle stop
// - three bit source select per enhanced counter
// - per counter overflow flags, enables, software clear
// - high byte steps two periods after low wrap
module pca_compare_pwm_wdt_unit #(
    parameter int N = pca_pkg::NUM_MODULES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // count sources and cpu state
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic baud_tick,
    input wire logic ext_count_pin,
    // module pins, reset and interrupt requests
    output logic [4:0] module_output_pin,
    output logic watchdog_reset,
    output logic irq_general,
    output logic [4:1] irq_module
);

    // ****************************************
    // state
    // ****************************************
    pca_pkg::ctrl_t ctrl_q;
    pca_pkg::mode_t mode_q [N];
    logic [7:0] cmp_lo_q [N];
    logic [7:0] cmp_hi_q [N];
    logic [15:0] cnt_q [N];
    logic [2:0] src_q [N];
    logic [1:0] hi_pend_q [N];
    logic [4:0] run_q, idle_stop_q, ovf_q, ovf_en_q, evt_q, pin_q;
    logic [4:0] upd_q, wrap_q;
    logic shared_ovf_q;
    logic [3:0] pre_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q, ext_fall_q;
    logic pready_q, pslverr_q, wdt_q, irq_gen_q;
    logic [31:0] prdata_q;
    logic [4:1] irq_mod_q;

    // ****************************************
    // bus decode
    // ****************************************
    logic setup, wr_en;
    logic [2:0] bank, idx;
    logic idx_ok, hit;
    logic wr_ctrl, wr_flags, wr_run, wr_ovf, wr_ovf_en, wr_idle, wr_pin;
    logic wr_mode, wr_lo, wr_hi, wr_cnt, wr_src;
    logic [31:0] rd_data;
    logic enh;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_q & pwrite;  // writes land at the access edge only
    assign bank = paddr[7:5];
    assign idx = paddr[4:2];
    assign idx_ok = (idx <= pca_pkg::LAST_MODULE_IDX) && (paddr[1:0] == 2'h0);
    // external counting mode wins, so enhanced is only live with it off
    assign enh = ctrl_q.enhanced_multi_base_mode & ~ctrl_q.ext_count_mode;

    // address decode and read mux
    always_comb
    begin
        hit = 1'b1;
        rd_data = 32'h0000_0000;
        wr_ctrl = 1'b0;
        wr_flags = 1'b0;
        wr_run = 1'b0;
        wr_ovf = 1'b0;
        wr_ovf_en = 1'b0;
        wr_idle = 1'b0;
        wr_pin = 1'b0;
        wr_mode = 1'b0;
        wr_lo = 1'b0;
        wr_hi = 1'b0;
        wr_cnt = 1'b0;
        wr_src = 1'b0;
        if (paddr == pca_pkg::ADDR_CTRL)
        begin
            rd_data[7:0] = ctrl_q;
            wr_ctrl = wr_en;
        end
        else if (paddr == pca_pkg::ADDR_FLAGS)
        begin
            rd_data[pca_pkg::FLAG_OVF_BIT] = shared_ovf_q;
            rd_data[4:0] = evt_q;
            wr_flags = wr_en;
        end
        else if (paddr == pca_pkg::ADDR_RUN)
        begin
            rd_data[4:0] = run_q;
            wr_run = wr_en;
        end
        else if (paddr == pca_pkg::ADDR_OVF)
        begin
            rd_data[4:0] = ovf_q;
            wr_ovf = wr_en;
        end
        else if (paddr == pca_pkg::ADDR_OVF_EN)
        begin
            rd_data[4:0] = ovf_en_q;
            wr_ovf_en = wr_en;
        end
        else if (paddr == pca_pkg::ADDR_IDLE)
        begin
            rd_data[4:0] = idle_stop_q;
            wr_idle = wr_en;
        end
        else if (paddr == pca_pkg::ADDR_PIN)
        begin
            rd_data[4:0] = pin_q;
            wr_pin = wr_en;
        end
        else if (idx_ok && bank == pca_pkg::BANK_MODE)
        begin
            rd_data[6:0] = mode_q[idx][6:0];  // reserved top bit reads zero
            wr_mode = wr_en;
        end
        else if (idx_ok && bank == pca_pkg::BANK_CMP_LO)
        begin
            rd_data[7:0] = cmp_lo_q[idx];
            wr_lo = wr_en;
        end
        else if (idx_ok && bank == pca_pkg::BANK_CMP_HI)
        begin
            rd_data[7:0] = cmp_hi_q[idx];
            wr_hi = wr_en;
        end
        else if (idx_ok && bank == pca_pkg::BANK_COUNT)
        begin
            rd_data[15:0] = cnt_q[idx];
            wr_cnt = wr_en;
        end
        else if (idx_ok && bank == pca_pkg::BANK_SRC)
        begin
            rd_data[2:0] = src_q[idx];
            wr_src = wr_en;
        end
        else
        begin
            hit = 1'b0;
        end
    end

    // apb answer: data and ready registered in setup, so no wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~hit;
            prdata_q <= (setup & ~pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // ****************************************
    // count pulse sources
    // ****************************************
    // one mod-12 prescaler serves both oscillator divisions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_q <= 4'h0;
        else if (pre_q == pca_pkg::DIV12_LAST)
            pre_q <= 4'h0;
        else
            pre_q <= pre_q + 4'h1;
    end

    // external pin: three flops, only a high to low fall counts, once stages two and three agree low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
            ext_s3_q <= 1'b1;
            ext_lvl_q <= 1'b1;
            ext_fall_q <= 1'b0;
        end
        else
        begin
            ext_s1_q <= ext_count_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            if (ext_s2_q == ext_s3_q)
                ext_lvl_q <= ext_s3_q;
            ext_fall_q <= ext_lvl_q & (ext_s2_q == ext_s3_q) & ~ext_s3_q;
        end
    end

    // per counter pulse selection and run gating
    logic tick_div12, tick_div4;
    logic [4:0] inc_lo, lo_wrap, hi_inc, hi_ovf, cnt_run;
    logic [2:0] sel;

    assign tick_div12 = (pre_q == pca_pkg::DIV12_LAST);
    assign tick_div4 = (pre_q[1:0] == pca_pkg::DIV4_PHASE);

    always_comb
    begin
        sel = 3'h0;
        for (int m = 0; m < N; m++)
        begin
            // shared mode only counter zero exists, the others hold still
            if (enh)
            begin
                sel = src_q[m];
                cnt_run[m] = run_q[m] & ~(cpu_idle & idle_stop_q[m]);
            end
            else
            begin
                sel = {1'b0, ctrl_q.source_select_bit1, ctrl_q.source_select_bit0};
                cnt_run[m] = (m == 0) & ctrl_q.shared_run_bit & ~(cpu_idle & ctrl_q.shared_idle_stop);
            end
            case (sel)
                pca_pkg::SRC_DIV12: inc_lo[m] = tick_div12;
                pca_pkg::SRC_DIV4: inc_lo[m] = tick_div4;
                pca_pkg::SRC_TIMER0: inc_lo[m] = timer0_overflow;
                pca_pkg::SRC_EXT_PIN: inc_lo[m] = ext_fall_q;
                pca_pkg::SRC_FAST: inc_lo[m] = tick_div4;
                pca_pkg::SRC_TIMER1: inc_lo[m] = timer1_overflow;
                pca_pkg::SRC_BAUD: inc_lo[m] = baud_tick;
                default: inc_lo[m] = 1'b0;
            endcase
            inc_lo[m] = inc_lo[m] & cnt_run[m];
            lo_wrap[m] = inc_lo[m] & (cnt_q[m][7:0] == pca_pkg::BYTE_MAX);
            hi_inc[m] = hi_pend_q[m][pca_pkg::HIGH_INC_DELAY - 1];
            hi_ovf[m] = hi_inc[m] & (cnt_q[m][15:8] == pca_pkg::BYTE_MAX);
        end
    end

    // ****************************************
    // counters
    // ****************************************
    // low byte counts, high byte follows two cycles after a low wrap; writes are refused while running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int m = 0; m < N; m++)
            begin
                cnt_q[m] <= pca_pkg::COUNT_RESET;
                hi_pend_q[m] <= 2'h0;
            end
            upd_q <= pca_pkg::BITS5_RESET;
            wrap_q <= pca_pkg::BITS5_RESET;
        end
        else
        begin
            for (int m = 0; m < N; m++)
            begin
                hi_pend_q[m] <= {hi_pend_q[m][0], lo_wrap[m]};
                if (wr_cnt && idx == 3'(m) && !cnt_run[m])
                    cnt_q[m] <= pwdata[15:0];
                else
                begin
                    if (inc_lo[m])
                        cnt_q[m][7:0] <= cnt_q[m][7:0] + 8'h01;
                    if (hi_inc[m])
                        cnt_q[m][15:8] <= cnt_q[m][15:8] + 8'h01;
                end
                // compare only on a fresh count value, so a match is one event
                upd_q[m] <= inc_lo[m] | hi_inc[m];
                wrap_q[m] <= lo_wrap[m];
            end
        end
    end

    // ****************************************
    // compare logic
    // ****************************************
    logic [4:0] match16, pwm_on, pwm_hit, pwm_wrap;
    logic [15:0] cnt_sel;

    always_comb
    begin
        cnt_sel = 16'h0000;
        for (int m = 0; m < N; m++)
        begin
            // enhanced gives each module its own counter, counter zero is the shared one
            cnt_sel = enh ? cnt_q[m] : cnt_q[0];
            match16[m] = (enh ? upd_q[m] : upd_q[0]) & (cnt_sel == {cmp_hi_q[m], cmp_lo_q[m]})
                       & mode_q[m].compare_enable & mode_q[m].equal_event_enable
                       & ~mode_q[m].pulse_mod_enable;
            pwm_on[m] = mode_q[m].compare_enable & mode_q[m].pulse_mod_enable;
            pwm_wrap[m] = pwm_on[m] & (enh ? wrap_q[m] : wrap_q[0]);
            pwm_hit[m] = pwm_on[m] & (enh ? upd_q[m] : upd_q[0]) & (cnt_sel[7:0] == cmp_lo_q[m]);
        end
    end

    // control register and simple per counter registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= pca_pkg::CTRL_RESET;
            run_q <= pca_pkg::BITS5_RESET;
            ovf_en_q <= pca_pkg::BITS5_RESET;
            idle_stop_q <= pca_pkg::BITS5_RESET;
            for (int m = 0; m < N; m++)
                src_q[m] <= pca_pkg::SRC_DIV12;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= pwdata[7:0];
            if (wr_run)
                run_q <= pwdata[4:0];
            if (wr_ovf_en)
                ovf_en_q <= pwdata[4:0];
            if (wr_idle)
                idle_stop_q <= pwdata[4:0];
            for (int m = 0; m < N; m++)
                if (wr_src && idx == 3'(m))
                    src_q[m] <= pwdata[2:0];
        end
    end

    // mode and compare bytes; byte writes steer compare_enable so a half update cannot match
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int m = 0; m < N; m++)
            begin
                mode_q[m] <= pca_pkg::MODE_RESET;
                cmp_lo_q[m] <= pca_pkg::BYTE_RESET;
                cmp_hi_q[m] <= pca_pkg::BYTE_RESET;
            end
        end
        else
        begin
            for (int m = 0; m < N; m++)
            begin
                if (wr_mode && idx == 3'(m))
                    mode_q[m] <= {1'b0, pwdata[6:0]};
                else if (wr_lo && idx == 3'(m))
                    mode_q[m].compare_enable <= 1'b0;
                else if (wr_hi && idx == 3'(m))
                    mode_q[m].compare_enable <= 1'b1;
                // a software low byte write in the wrap cycle wins over the reload
                if (wr_lo && idx == 3'(m))
                    cmp_lo_q[m] <= pwdata[7:0];
                else if (pwm_wrap[m])
                    cmp_lo_q[m] <= cmp_hi_q[m];
                if (wr_hi && idx == 3'(m))
                    cmp_hi_q[m] <= pwdata[7:0];
            end
        end
    end

    // ****************************************
    // flags
    // ****************************************
    // write one to clear; a set in the same cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_q <= pca_pkg::BITS5_RESET;
            ovf_q <= pca_pkg::BITS5_RESET;
            shared_ovf_q <= 1'b0;
        end
        else
        begin
            evt_q <= (evt_q & ~(wr_flags ? pwdata[4:0] : 5'h00)) | match16;
            ovf_q <= (ovf_q & ~(wr_ovf ? pwdata[4:0] : 5'h00)) | (enh ? hi_ovf : 5'h00);
            shared_ovf_q <= (shared_ovf_q & ~(wr_flags & pwdata[pca_pkg::FLAG_OVF_BIT]))
                          | (~enh & hi_ovf[0]);
        end
    end

    // ****************************************
    // module pins
    // ****************************************
    // pwm owns the pin while enabled; otherwise software presets it and a match flips it in pin flip mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_q <= pca_pkg::BITS5_RESET;
        else
        begin
            for (int m = 0; m < N; m++)
            begin
                if (pwm_wrap[m])
                    pin_q[m] <= (cmp_hi_q[m] == pca_pkg::BYTE_ZERO);
                else if (pwm_hit[m])
                    pin_q[m] <= 1'b1;
                else if (pwm_on[m])
                    pin_q[m] <= pin_q[m];
                else if (match16[m] && mode_q[m].pin_flip_enable)
                    pin_q[m] <= ~pin_q[m];
                else if (wr_pin)
                    pin_q[m] <= pwdata[m];
            end
        end
    end

    // ****************************************
    // watchdog and interrupt requests
    // ****************************************
    // registered one cycle pulse per module four match while reset enable is set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wdt_q <= 1'b0;
        else
            wdt_q <= match16[pca_pkg::WDT_MODULE] & ctrl_q.watchdog_reset_enable;
    end

    // enhanced splits module flags 1 to 4 onto their own lines
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_gen_q <= 1'b0;
            irq_mod_q <= 4'h0;
        end
        else if (enh)
        begin
            irq_gen_q <= (evt_q[0] & mode_q[0].module_flag_irq_enable) | (|(ovf_q & ovf_en_q));
            for (int m = 1; m < N; m++)
                irq_mod_q[m] <= evt_q[m] & mode_q[m].module_flag_irq_enable;
        end
        else
        begin
            irq_gen_q <= (shared_ovf_q & ctrl_q.shared_overflow_irq_enable)
                       | (evt_q[0] & mode_q[0].module_flag_irq_enable)
                       | (evt_q[1] & mode_q[1].module_flag_irq_enable)
                       | (evt_q[2] & mode_q[2].module_flag_irq_enable)
                       | (evt_q[3] & mode_q[3].module_flag_irq_enable)
                       | (evt_q[4] & mode_q[4].module_flag_irq_enable);
            irq_mod_q <= 4'h0;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign module_output_pin = pin_q;
    assign watchdog_reset = wdt_q;
    assign irq_general = irq_gen_q;
    assign irq_module = irq_mod_q;

endmodule
`default_nettype wire

// ### pca_pkg.sv
// shared constants and types for the compare, pwm and watchdog timer array
package pca_pkg;

    // ****************************************
    // array geometry
    // ****************************************
    localparam int NUM_MODULES = 5;
    localparam int WDT_MODULE = 4;
    localparam logic [2:0] LAST_MODULE_IDX = 3'h4;

    // ****************************************
    // count pulse timing
    // ****************************************
    localparam logic [3:0] DIV12_LAST = 4'hB;      // prescaler wraps after twelve cycles
    localparam logic [1:0] DIV4_PHASE = 2'h3;      // every fourth prescaler step
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int HIGH_INC_DELAY = 2;             // oscillator periods from low wrap to high step

    // ****************************************
    // count pulse sources
    // ****************************************
    typedef enum logic [2:0] {
        SRC_DIV12 = 3'h0,
        SRC_DIV4 = 3'h1,
        SRC_TIMER0 = 3'h2,
        SRC_EXT_PIN = 3'h3,
        SRC_FAST = 3'h4,
        SRC_TIMER1 = 3'h5,
        SRC_RESERVED = 3'h6,
        SRC_BAUD = 3'h7
    } src_t;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_RUN = 8'h08;
    localparam logic [7:0] ADDR_OVF = 8'h0C;
    localparam logic [7:0] ADDR_OVF_EN = 8'h10;
    localparam logic [7:0] ADDR_IDLE = 8'h14;
    localparam logic [7:0] ADDR_PIN = 8'h18;
    // banks of five words, bank number in address bits 7:5, module in bits 4:2
    localparam logic [2:0] BANK_MODE = 3'h1;
    localparam logic [2:0] BANK_CMP_LO = 3'h2;
    localparam logic [2:0] BANK_CMP_HI = 3'h3;
    localparam logic [2:0] BANK_COUNT = 3'h4;
    localparam logic [2:0] BANK_SRC = 3'h5;
    localparam int FLAG_OVF_BIT = 7;

    // ****************************************
    // register layouts and reset values
    // ****************************************
    typedef struct packed {
        logic ext_count_mode;
        logic enhanced_multi_base_mode;
        logic shared_overflow_irq_enable;
        logic source_select_bit1;
        logic source_select_bit0;
        logic watchdog_reset_enable;
        logic shared_idle_stop;
        logic shared_run_bit;
    } ctrl_t;

    typedef struct packed {
        logic reserved;
        logic compare_enable;
        logic capture_pos;
        logic capture_neg;
        logic equal_event_enable;
        logic pin_flip_enable;
        logic pulse_mod_enable;
        logic module_flag_irq_enable;
    } mode_t;

    localparam ctrl_t CTRL_RESET = 8'h00;
    localparam mode_t MODE_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [4:0] BITS5_RESET = 5'h00;

endpackage

// ### pca_unit_properties.sv
// checker of apb timing, watchdog gating and interrupt gating of the timer array
`timescale 1ns/1ps
`default_nettype none
module pca_unit_properties #(parameter int N = 5) (
    // clock, reset and apb
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr,
    // count sources and cpu state
    input wire logic cpu_idle, timer0_overflow, timer1_overflow, baud_tick, ext_count_pin,
    // pins and requests
    input wire logic [4:0] module_output_pin,
    input wire logic watchdog_reset, irq_general,
    input wire logic [4:1] irq_module
);
    // ****
    // control word shadow, taken where a write lands
    // ****
    logic [7:0] ctrl_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= 8'h00;
        else if (psel && penable && pready && pwrite && paddr == pca_pkg::ADDR_CTRL)
            ctrl_q <= pwdata[7:0];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable && pready; endsequence
    // ****
    // properties
    // ****
    a_ready_after_setup: assert property (setup_s |=> access_s) else $error("no ready after setup");
    a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_bad_addr_error: assert property (pready && (paddr[1:0] != 2'h0 || paddr >= 8'hC0) |-> pslverr)
        else $error("bad address accepted");
    a_idle_read_zero: assert property (!pready || pslverr |-> prdata == 32'h0) else $error("stray read data");
    a_wdt_one_pulse: assert property (watchdog_reset |=> !watchdog_reset) else $error("long reset");
    a_wdt_needs_enable: assert property (watchdog_reset |-> $past(ctrl_q[2]) || $past(ctrl_q[2], 2))
        else $error("reset while disabled");
    // stale flags may not leak once enhanced mode is off or overridden
    a_module_irq_shared: assert property ((!ctrl_q[6] || ctrl_q[7]) [*3] |-> irq_module == 4'h0)
        else $error("module irq outside enhanced");
endmodule
bind pca_compare_pwm_wdt_unit pca_unit_properties #(.N(N)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
    .timer1_overflow(timer1_overflow), .baud_tick(baud_tick), .ext_count_pin(ext_count_pin),
    .module_output_pin(module_output_pin), .watchdog_reset(watchdog_reset), .irq_general(irq_general),
    .irq_module(irq_module));
`default_nettype wire

// ### testbench.sv
// self-checking testbench of the timer array compare side
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, watchdog_reset, irq_general, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] module_output_pin;
    logic [4:1] irq_module;
    int n_errors, tests_run, wdt_count, k, n;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
    row_t rows [15] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h04, 0, 0, 0}, '{0, 8'h90, 0, 0, 0},
        '{1, 8'h2C, 32'hFF, 32'h7F, 0}, '{1, 8'hAC, 32'hFF, 32'h7, 0}, '{1, 8'h4C, 32'h12, 32'h12, 0},
        '{0, 8'h2C, 0, 32'h3F, 0}, '{1, 8'h6C, 32'h34, 32'h34, 0}, '{0, 8'h2C, 0, 32'h7F, 0},
        '{1, 8'h2C, 0, 0, 0}, '{1, 8'hAC, 0, 0, 0}, '{1, 8'h80, 32'h1234, 32'h1234, 0},
        '{1, 8'h80, 0, 0, 0}, '{1, 8'hFC, 32'h55, 0, 1}, '{1, 8'h42, 32'h55, 0, 1}};
    // spare sources are tied: only the divided oscillator is exercised
    pca_compare_pwm_wdt_unit #(.N(pca_pkg::NUM_MODULES)) u_pca_compare_pwm_wdt_unit (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(1'b0), .timer0_overflow(1'b0),
        .timer1_overflow(1'b0), .baud_tick(1'b0), .ext_count_pin(1'b0), .module_output_pin(module_output_pin),
        .watchdog_reset(watchdog_reset), .irq_general(irq_general), .irq_module(irq_module));
    // ****
    // clock, watchdog and reset pulse counter
    // ****
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        #300000;
        n_errors++;
        complete_run();
    end
    always @(posedge pclk)
        if (watchdog_reset === 1'b1)
            wdt_count++;
    // ****
    // compare, bus and closing tasks
    // ****
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    // holds the request until ready is sampled, then idles one cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk_word(rd & m, x);
    endtask
    task automatic complete_run();
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****
    // main sequence
    // ****
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].x, 32'hFFFFFFFF);
            chk_bit(err, rows[i].e);
        end
        // compare values before modes; module 0 timer, 1 toggle, 2 pwm, 4 watchdog
        wr(8'h40, 32'h10);
        wr(8'h60, 32'h0);
        wr(8'h44, 32'h20);
        wr(8'h64, 32'h0);
        wr(8'h48, 32'h80);
        wr(8'h68, 32'h80);
        wr(8'h50, 32'h30);
        wr(8'h70, 32'h0);
        wr(8'h20, 32'h49);
        wr(8'h24, 32'h4C);
        wr(8'h28, 32'h42);
        wr(8'h30, 32'h48);
        wr(8'h18, 32'h02);
        chk_bit(module_output_pin[1], 1'b1);
        wr(8'h00, 32'h0D);
        for (k = 0; k < 300 && irq_general !== 1'b1; k++) @(posedge pclk);
        chk_bit(irq_general, 1'b1);
        for (k = 0; k < 300 && wdt_count == 0; k++) @(posedge pclk);
        chk_word(32'(wdt_count), 32'h1);
        chk_bit(module_output_pin[1], 1'b0);
        chk_bit(module_output_pin[2], 1'b0);
        rdchk(8'h04, 32'h13, 32'h1F);
        for (k = 0; k < 800 && module_output_pin[2] !== 1'b1; k++) @(posedge pclk);
        chk_bit(module_output_pin[2], 1'b1);
        for (k = 0; k < 2000 && module_output_pin[2] === 1'b1; k++) @(posedge pclk);
        for (n = k; n < 2000 && module_output_pin[2] !== 1'b1; n++) @(posedge pclk);
        chk_word(32'(n), 32'h400);
        wr(8'h68, 32'h0);
        repeat (1100) @(posedge pclk);
        chk_bit(module_output_pin[2], 1'b1);
        rdchk(8'h48, 32'h0, 32'hFF);
        rdchk(8'h04, 32'h13, 32'h1F);
        wr(8'h04, 32'h1F);
        rdchk(8'h04, 32'h0, 32'h1F);
        // stop before reloading: counter writes are dropped while running
        wr(8'h00, 32'h08);
        wr(8'h80, 32'h2C);
        wr(8'h00, 32'h09);
        repeat (100) @(posedge pclk);
        chk_word(32'(wdt_count), 32'h1);
        rdchk(8'h04, 32'h10, 32'h10);
        wr(8'h00, 32'h40);
        wr(8'hAC, 32'h4);
        wr(8'h4C, 32'h05);
        wr(8'h6C, 32'h0);
        wr(8'h2C, 32'h49);
        wr(8'h8C, 32'hFFFE);
        wr(8'h08, 32'h08);
        for (k = 0; k < 100 && irq_module[3] !== 1'b1; k++) @(posedge pclk);
        chk_bit(irq_module[3], 1'b1);
        chk_bit(irq_general, 1'b0);
        wr(8'h10, 32'h8);
        rdchk(8'h0C, 32'h8, 32'h1F);
        chk_bit(irq_general, 1'b1);
        wr(8'hB0, 32'h6);
        wr(8'h08, 32'h18);
        repeat (60) @(posedge pclk);
        rdchk(8'h90, 32'h0, 32'hFFFF);
        complete_run();
    end
endmodule
`default_nettype wire
